// *** shared/csf_status_map.svh ***
// csf_status_map.svh: offsets, bit positions, reset values
// assumes inclusion by the status register package users only
`ifndef CSF_STATUS_MAP_SVH
`define CSF_STATUS_MAP_SVH

// register offset on the control bus (byte address)
`define CSF_STATUS_OFFSET 4'h0
// bit positions inside the status register
`define CSF_BIT_TO 4
`define CSF_BIT_PD 3
`define CSF_BIT_Z 2
`define CSF_BIT_DC 1
`define CSF_BIT_C 0
// writable field is bits 2..0
`define CSF_WR_MSB 2
// power-on / brown-out value of the five stored bits
`define CSF_POR_VALUE 5'h18
// bus responses
`define CSF_RESP_OKAY 2'h0
`define CSF_RESP_SLVERR 2'h2

`endif

// *** shared/csf_pkg.sv ***
// csf_pkg: types shared by the status register and its flag logic
// assumes nothing beyond a standard elaborator
package csf_pkg;

   // operation presented by the core execution path
   typedef enum logic [3:0] {
      CSF_OP_ADD = 4'h0,
      CSF_OP_SUB = 4'h1,
      CSF_OP_AND = 4'h2,
      CSF_OP_OR = 4'h3,
      CSF_OP_XOR = 4'h4,
      CSF_OP_CLEAR = 4'h5,
      CSF_OP_BIT_CLR = 4'h6,
      CSF_OP_BIT_SET = 4'h7,
      CSF_OP_SWAP = 4'h8,
      CSF_OP_MOVE_W = 4'h9
   } csf_op_t;

endpackage

// *** core/csf_alu_flags.sv ***
// csf_alu_flags: result and flag logic for one instruction
// assumes operands stable in the cycle they are presented
`timescale 1ns/10ps
module csf_alu_flags
(
   // operation and operands
   input wire csf_pkg::csf_op_t op,
   input wire logic [7:0] w,
   input wire logic [7:0] f,
   input wire logic [2:0] bit_sel,
   // result and flags
   output logic [7:0] res,
   output logic z,
   output logic dc,
   output logic c,
   // which flags this operation drives
   output logic aff_z,
   output logic aff_dc,
   output logic aff_c
);
   import csf_pkg::*;

   // 8-bit add with carry in; returns {carry, digit carry, sum}
   function automatic logic [9:0] add_flags(input logic [7:0] a,
      input logic [7:0] b, input logic cin);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      return {full[8], low[4], full[7:0]};
   endfunction

   // result per operation and the flags it owns
   always_comb
   begin
      logic [9:0] sum;
      sum = 10'h000;
      res = f;
      dc = 1'b0;
      c = 1'b0;
      aff_z = 1'b0;
      aff_dc = 1'b0;
      aff_c = 1'b0;
      case (op)
         CSF_OP_ADD:
         begin
            sum = add_flags(w, f, 1'b0); // RULE9 RULE12
            res = sum[7:0];
            {c, dc} = sum[9:8];
            {aff_z, aff_dc, aff_c} = 3'h7;
         end
         CSF_OP_SUB:
         begin
            sum = add_flags(f, ~w, 1'b1); // RULE10
            res = sum[7:0];
            {c, dc} = sum[9:8];
            {aff_z, aff_dc, aff_c} = 3'h7;
         end
         CSF_OP_AND:
         begin
            res = w & f;
            aff_z = 1'b1;
         end
         CSF_OP_OR:
         begin
            res = w | f;
            aff_z = 1'b1;
         end
         CSF_OP_XOR:
         begin
            res = w ^ f;
            aff_z = 1'b1;
         end
         CSF_OP_CLEAR:
         begin
            res = 8'h00;
            aff_z = 1'b1;
         end
         // these touch no flag
         CSF_OP_BIT_CLR: res = f & ~(8'h01 << bit_sel); // RULE6
         CSF_OP_BIT_SET: res = f | (8'h01 << bit_sel); // RULE6
         CSF_OP_SWAP: res = {f[3:0], f[7:4]}; // RULE6
         CSF_OP_MOVE_W: res = w; // RULE6
         default: res = f;
      endcase
      z = (res == 8'h00); // RULE8
   end

endmodule // csf_alu_flags

// *** core/csf_status_reg.sv ***
// csf_status_reg: processor status register with AXI4-Lite access
// assumes core execution ports and event strobes on aclk
// Operation
// RULE1: status register accepted as any instruction destination
// RULE2: self-updated flags ignore the written data
// RULE3: time-out and power-down flags ignore writes
// RULE4: clear on status gives 000u u1uu
// RULE5: software should alter status with four instructions
// RULE6: bit, swap, move store written bits exactly
// RULE7: power-down set by power-up/clear, cleared by sleep
// RULE8: zero flag reflects a zero result
// RULE9: digit carry is carry out of bit 3
// RULE10: subtraction flags are inverted borrows
// RULE11: time-out set by power-up/clear/sleep, cleared on expiry
// RULE12: carry out of msb; bits 7..5 read zero
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "csf_status_map.svh"
module csf_status_reg
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic por_reset,
   // instruction execution path
   input wire logic instr_valid,
   input wire csf_pkg::csf_op_t instr_op,
   input wire logic instr_dest_status,
   input wire logic [7:0] instr_w,
   input wire logic [7:0] instr_f,
   input wire logic [2:0] instr_bit,
   // reset cause events
   input wire logic watchdog_clear_instr,
   input wire logic sleep_instr,
   input wire logic watchdog_timeout,
   // results to the core
   output logic [7:0] status_flags,
   output logic [7:0] result_data,
   output logic result_valid,
   // axi4-lite write
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import csf_pkg::*;

   logic [4:0] st_q, st_d;
   logic [7:0] res_q, res_d;
   logic rv_q, rv_d;
   logic [7:0] alu_res;
   logic alu_z, alu_dc, alu_c, aff_z, aff_dc, aff_c;
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d;
   logic [3:0] awa_q, awa_d, wst_q, wst_d;
   logic [2:0] wd_q, wd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic rvl_q, rvl_d;
   logic [7:0] rd_q, rd_d;
   logic commit;

   // flag and result logic
   csf_alu_flags u_alu
   (
      .op(instr_op),
      .w(instr_w),
      .f(instr_f),
      .bit_sel(instr_bit),
      .res(alu_res),
      .z(alu_z),
      .dc(alu_dc),
      .c(alu_c),
      .aff_z(aff_z),
      .aff_dc(aff_dc),
      .aff_c(aff_c)
   );

   // bus write lands only when no instruction owns the register
   assign commit = aw_q && w_q && !bv_q && !instr_valid;

   // next status value: instruction, bus write, then events
   always_comb
   begin
      st_d = st_q;
      res_d = res_q;
      rv_d = instr_valid;
      if (instr_valid)
      begin
         res_d = alu_res;
         if (instr_dest_status && instr_op == CSF_OP_CLEAR)
            st_d[`CSF_BIT_Z] = 1'b1; // RULE4
         else
         begin
            if (instr_dest_status)
               st_d[`CSF_WR_MSB:0] = alu_res[`CSF_WR_MSB:0]; // RULE1 RULE6
            if (aff_z)
               st_d[`CSF_BIT_Z] = alu_z; // RULE2 RULE8
            if (aff_dc)
               st_d[`CSF_BIT_DC] = alu_dc; // RULE2 RULE9 RULE10
            if (aff_c)
               st_d[`CSF_BIT_C] = alu_c; // RULE2 RULE10 RULE12
         end
      end
      else if (commit && awa_q == `CSF_STATUS_OFFSET && wst_q[0])
         st_d[`CSF_WR_MSB:0] = wd_q; // RULE3
      if (watchdog_clear_instr)
         st_d[`CSF_BIT_TO:`CSF_BIT_PD] = 2'h3; // RULE7 RULE11
      if (sleep_instr)
         st_d[`CSF_BIT_TO:`CSF_BIT_PD] = 2'h2; // RULE7 RULE11
      if (watchdog_timeout)
         st_d[`CSF_BIT_TO] = 1'b0; // RULE11
   end

   // status register; non power-on resets keep the flags
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         if (por_reset)
            st_q <= `CSF_POR_VALUE; // RULE7 RULE11
         res_q <= 8'h00;
         rv_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         res_q <= res_d;
         rv_q <= rv_d;
      end
   end

   assign status_flags = {3'h0, st_q}; // RULE12
   assign result_data = res_q;
   assign result_valid = rv_q;

   // axi write channel: hold address and data, answer once both held
   always_comb
   begin
      aw_d = aw_q;
      w_d = w_q;
      bv_d = bv_q;
      awa_d = awa_q;
      wst_d = wst_q;
      wd_d = wd_q;
      br_d = br_q;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_d = 1'b1;
         wd_d = s_axi_wdata[`CSF_WR_MSB:0];
         wst_d = s_axi_wstrb;
      end
      if (commit)
      begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = (awa_q == `CSF_STATUS_OFFSET) ? `CSF_RESP_OKAY :
            `CSF_RESP_SLVERR;
      end
      if (bv_q && s_axi_bready)
         bv_d = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bv_q <= 1'b0;
         awa_q <= 4'h0;
         wst_q <= 4'h0;
         wd_q <= 3'h0;
         br_q <= `CSF_RESP_OKAY;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         aw_q <= aw_d;
         w_q <= w_d;
         bv_q <= bv_d;
         awa_q <= awa_d;
         wst_q <= wst_d;
         wd_q <= wd_d;
         br_q <= br_d;
         s_axi_awready <= !aw_d && !bv_d;
         s_axi_wready <= !w_d && !bv_d;
      end
   end

   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;

   // axi read channel: one cycle from address to data
   always_comb
   begin
      rvl_d = rvl_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rvl_d = 1'b1;
         rd_d = (s_axi_araddr == `CSF_STATUS_OFFSET) ? {3'h0, st_q} : 8'h00;
         rr_d = (s_axi_araddr == `CSF_STATUS_OFFSET) ? `CSF_RESP_OKAY :
            `CSF_RESP_SLVERR;
      end
      else if (rvl_q && s_axi_rready)
         rvl_d = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvl_q <= 1'b0;
         rd_q <= 8'h00;
         rr_q <= `CSF_RESP_OKAY;
         s_axi_arready <= 1'b0;
      end
      else
      begin
         rvl_q <= rvl_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
         s_axi_arready <= !rvl_d;
      end
   end

   assign s_axi_rvalid = rvl_q;
   assign s_axi_rdata = {24'h00_0000, rd_q};
   assign s_axi_rresp = rr_q;

   // checks on the flag behaviour and the write response
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_upper_zero: assert property (status_flags[7:5] == 3'h0) // RULE12
      else $error("upper status bits not zero");
   a_cause_hold: assert property ( // RULE3
      !watchdog_clear_instr && !sleep_instr && !watchdog_timeout
      |=> $stable(st_q[`CSF_BIT_TO:`CSF_BIT_PD]))
      else $error("reset cause bits changed without event");
   a_clear_patt: assert property ( // RULE4
      instr_valid && instr_dest_status && instr_op == CSF_OP_CLEAR &&
      !watchdog_clear_instr && !sleep_instr && !watchdog_timeout
      |=> st_q == {$past(st_q[4:3]), 1'b1, $past(st_q[1:0])})
      else $error("clear on status gave wrong pattern");
   a_move_exact: assert property ( // RULE6
      instr_valid && instr_dest_status && instr_op == CSF_OP_MOVE_W
      |=> st_q[2:0] == $past(instr_w[2:0]))
      else $error("move to status not stored exactly");
   a_sleep_pd: assert property ( // RULE7
      sleep_instr && !watchdog_timeout
      |=> st_q[`CSF_BIT_PD] == 1'b0 && st_q[`CSF_BIT_TO] == 1'b1)
      else $error("sleep did not update cause bits");
   a_timeout_to: assert property (watchdog_timeout |=> // RULE11
      !st_q[`CSF_BIT_TO] &&
      (st_q[`CSF_BIT_PD] == $past(st_q[`CSF_BIT_PD]) ||
      $past(sleep_instr || watchdog_clear_instr)))
      else $error("time-out flag not cleared");
   a_zero_flag: assert property ( // RULE8
      instr_valid && !instr_dest_status && instr_op == CSF_OP_XOR
      |=> st_q[`CSF_BIT_Z] == ($past(instr_w) == $past(instr_f)) &&
      result_valid)
      else $error("zero flag mismatch");
   a_add_carry: assert property ( // RULE9
      instr_valid && !instr_dest_status && instr_op == CSF_OP_ADD
      |=> st_q[1:0] == {$past(instr_w[3:0]) > ~$past(instr_f[3:0]),
         $past(instr_w) > ~$past(instr_f)})
      else $error("add carry flags wrong");
   a_sub_borrow: assert property ( // RULE10
      instr_valid && !instr_dest_status && instr_op == CSF_OP_SUB
      |=> st_q[`CSF_BIT_C] == ($past(instr_f) >= $past(instr_w)))
      else $error("subtract borrow polarity wrong");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");

   c_clear_status: cover property (instr_valid && instr_dest_status &&
      instr_op == CSF_OP_CLEAR);
   c_bus_write: cover property (s_axi_bvalid && s_axi_bready);
   c_sleep_wake: cover property (sleep_instr ##[1:20] watchdog_timeout);

endmodule // csf_status_reg

// *** test/csf_core_model.sv ***
// csf_core_model: instruction path and event source facing the status reg
// assumes status_flags is read back as the file operand when targeted
`timescale 1ns/10ps
module csf_core_model
(
   // clock and flags
   input wire logic aclk,
   input wire logic [7:0] status_flags,
   // instruction issue
   output logic instr_valid,
   output csf_pkg::csf_op_t instr_op,
   output logic instr_dest_status,
   output logic [7:0] instr_w,
   output logic [7:0] instr_f,
   output logic [2:0] instr_bit,
   // reset cause events
   output logic watchdog_clear_instr,
   output logic sleep_instr,
   output logic watchdog_timeout
);
   import csf_pkg::*;

   // quiet start
   initial
   begin
      instr_valid = 1'b0;
      instr_op = CSF_OP_ADD;
      instr_dest_status = 1'b0;
      instr_w = 8'h00;
      instr_f = 8'h00;
      instr_bit = 3'h0;
      {watchdog_clear_instr, sleep_instr, watchdog_timeout} = 3'h0;
   end

   // one instruction, one cycle; operands garbled once released
   task automatic exec(input csf_op_t op, input logic [7:0] w, f,
      input logic [2:0] b, input logic dst);
      @(posedge aclk);
      instr_valid <= 1'b1;
      instr_op <= op;
      instr_w <= w;
      instr_f <= dst ? status_flags : f;
      instr_bit <= b;
      instr_dest_status <= dst;
      @(posedge aclk);
      instr_valid <= 1'b0;
      instr_w <= ~w;
      instr_f <= ~instr_f;
      instr_dest_status <= ~dst;
   endtask

   // one-cycle pulse of {clear, sleep, timeout}
   task automatic pulse(input logic [2:0] sel);
      @(posedge aclk);
      {watchdog_clear_instr, sleep_instr, watchdog_timeout} <= sel;
      @(posedge aclk);
      {watchdog_clear_instr, sleep_instr, watchdog_timeout} <= 3'h0;
   endtask
endmodule // csf_core_model

// *** test/csf_status_reg_bench.sv ***
// csf_status_reg_bench: self-checking bench for the status register
// assumes the core model drives the instruction and event ports
`timescale 1ns/10ps
`include "csf_status_map.svh"
module csf_status_reg_bench;
   import csf_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic por_reset = 1'b1;
   logic instr_valid, instr_dest_status, result_valid;
   csf_op_t instr_op;
   logic [7:0] instr_w, instr_f, status_flags, result_data;
   logic [2:0] instr_bit;
   logic watchdog_clear_instr, sleep_instr, watchdog_timeout;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int n_fail = 0, comparisons = 0, cycles = 0;

   csf_status_reg uut (.aclk, .aresetn, .por_reset, .instr_valid,
      .instr_op, .instr_dest_status, .instr_w, .instr_f, .instr_bit,
      .watchdog_clear_instr, .sleep_instr, .watchdog_timeout,
      .status_flags, .result_data, .result_valid, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   csf_core_model core (.aclk, .status_flags, .instr_valid, .instr_op,
      .instr_dest_status, .instr_w, .instr_f, .instr_bit,
      .watchdog_clear_instr, .sleep_instr, .watchdog_timeout);

   // 25 MHz clock
   always #20 aclk = ~aclk;

   // hang guard
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         summarize();
      end
   end

   task automatic summarize;
      $display("mismatches %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // reset held five cycles, power-on kind or not
   task automatic do_reset(input logic por);
      @(posedge aclk);
      aresetn <= 1'b0;
      por_reset <= por;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
   endtask

   // bus write: address and data offered together, bready held
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check(s_axi_bresp, r);
   endtask

   // bus read, rready held until rvalid
   task automatic axi_rd(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, d);
      check(s_axi_rresp, r);
   endtask

   // one instruction, then status, result and strobe
   task automatic op_chk(input csf_op_t op, input logic [7:0] w, f,
      input logic [2:0] b, input logic dst, input logic [7:0] st, res);
      core.exec(op, w, f, b, dst);
      #1;
      check(status_flags, st);
      check(result_data, res);
      check(result_valid, 1'b1);
      // strobe stands for one cycle only
      @(posedge aclk);
      #1;
      check(result_valid, 1'b0);
   endtask

   // event pulse, then status once settled
   task automatic ev(input logic [2:0] sel, input logic [7:0] st);
      core.pulse(sel);
      repeat (2) @(posedge aclk);
      #1;
      check(status_flags, st);
   endtask

   // every operation code, flags only, destination elsewhere
   task automatic t_alu_flags;
      op_chk(CSF_OP_ADD, 8'h0F, 8'h01, 3'h0, 1'b0, 8'h1A, 8'h10);
      op_chk(CSF_OP_ADD, 8'hFF, 8'h01, 3'h0, 1'b0, 8'h1F, 8'h00);
      op_chk(CSF_OP_SUB, 8'h01, 8'h10, 3'h0, 1'b0, 8'h19, 8'h0F);
      op_chk(CSF_OP_SUB, 8'h01, 8'h01, 3'h0, 1'b0, 8'h1F, 8'h00);
      op_chk(CSF_OP_SUB, 8'h02, 8'h01, 3'h0, 1'b0, 8'h18, 8'hFF);
      op_chk(CSF_OP_AND, 8'h0F, 8'hF0, 3'h0, 1'b0, 8'h1C, 8'h00);
      op_chk(CSF_OP_OR, 8'h01, 8'h00, 3'h0, 1'b0, 8'h18, 8'h01);
      op_chk(CSF_OP_XOR, 8'hAA, 8'hAA, 3'h0, 1'b0, 8'h1C, 8'h00);
      op_chk(CSF_OP_CLEAR, 8'h55, 8'h77, 3'h0, 1'b0, 8'h1C, 8'h00);
      op_chk(CSF_OP_BIT_SET, 8'h00, 8'h00, 3'h3, 1'b0, 8'h1C, 8'h08);
      op_chk(CSF_OP_BIT_CLR, 8'h00, 8'hFF, 3'h0, 1'b0, 8'h1C, 8'hFE);
      op_chk(CSF_OP_SWAP, 8'h00, 8'h12, 3'h0, 1'b0, 8'h1C, 8'h21);
      op_chk(CSF_OP_MOVE_W, 8'h5A, 8'h00, 3'h0, 1'b0, 8'h1C, 8'h5A);
   endtask

   // status as destination, starting from 8'h1C
   task automatic t_status_dest;
      op_chk(CSF_OP_MOVE_W, 8'hFF, 8'h00, 3'h0, 1'b1, 8'h1F, 8'hFF);
      op_chk(CSF_OP_BIT_CLR, 8'h00, 8'h00, 3'h1, 1'b1, 8'h1D, 8'h1D);
      op_chk(CSF_OP_BIT_CLR, 8'h00, 8'h00, 3'h4, 1'b1, 8'h1D, 8'h0D);
      op_chk(CSF_OP_SWAP, 8'h00, 8'h00, 3'h0, 1'b1, 8'h19, 8'hD1);
      op_chk(CSF_OP_CLEAR, 8'h00, 8'h00, 3'h0, 1'b1, 8'h1D, 8'h00);
      op_chk(CSF_OP_ADD, 8'h03, 8'h00, 3'h0, 1'b1, 8'h1A, 8'h20);
      op_chk(CSF_OP_XOR, 8'h1A, 8'h00, 3'h0, 1'b1, 8'h1C, 8'h00);
   endtask

   // reset-cause flags from events, immune to instruction writes
   task automatic t_events;
      ev(3'b010, 8'h14);
      ev(3'b001, 8'h04);
      op_chk(CSF_OP_MOVE_W, 8'hFF, 8'h00, 3'h0, 1'b1, 8'h07, 8'hFF);
      ev(3'b100, 8'h1F);
   endtask

   // register access over the bus, starting from 8'h1F
   task automatic t_bus;
      axi_rd(4'h0, 32'h0000_001F, `CSF_RESP_OKAY);
      axi_wr(4'h0, 32'h0000_0FF8, 4'h1, `CSF_RESP_OKAY);
      check(status_flags, 8'h18);
      axi_wr(4'h0, 32'h0000_0007, 4'h0, `CSF_RESP_OKAY);
      axi_wr(4'h4, 32'h0000_0007, 4'h1, `CSF_RESP_SLVERR);
      check(status_flags, 8'h18);
      axi_rd(4'h4, 32'h0000_0000, `CSF_RESP_SLVERR);
      axi_wr(4'h0, 32'h0000_0005, 4'h1, `CSF_RESP_OKAY);
      axi_rd(4'h0, 32'h0000_001D, `CSF_RESP_OKAY);
   endtask

   // bus write meeting an instruction waits for it, then lands
   task automatic t_contend;
      fork
         axi_wr(4'h0, 32'h0000_0004, 4'h1, `CSF_RESP_OKAY);
         begin
            @(posedge aclk);
            op_chk(CSF_OP_MOVE_W, 8'h02, 8'h00, 3'h0, 1'b1, 8'h1A,
               8'h02);
         end
      join
      check(status_flags, 8'h1C);
   endtask

   // warm reset keeps the bits, power-on reset restores them
   task automatic t_resets;
      do_reset(1'b0);
      check(status_flags, 8'h1C);
      check(result_data, 8'h00);
      check({s_axi_awready, s_axi_wready, s_axi_arready}, 3'h7);
      do_reset(1'b1);
      check(status_flags, 8'h18);
   endtask

   // main sequence
   initial
   begin
      do_reset(1'b1);
      check(status_flags, 8'h18);
      t_alu_flags();
      t_status_dest();
      t_events();
      t_bus();
      t_contend();
      t_resets();
      summarize();
   end
endmodule // csf_status_reg_bench
